// ===== rtl/pin_mux_consts.vh
/*
  Register offsets, field positions and reset values of the pin function mux.
  Assumes inclusion by the mux module only; byte addresses, one 32-bit word each.
*/
`ifndef PIN_MUX_CONSTS_VH
`define PIN_MUX_CONSTS_VH

`define ADDR_PIN_SELECT      8'h00
`define ADDR_GPIO_DIRECTION  8'h04
`define ADDR_GPIO_OUTPUT     8'h08
`define ADDR_GPIO_INPUT      8'h0C
`define ADDR_TEST_SELECT     8'h10
`define ADDR_STATUS          8'h14

`define SEL_EEPROM_BIT       8
`define SEL_PULSE_BIT        9
`define SEL_SPI_BIT          10
`define SEL_CLOCK_TEST_BIT   11
`define SEL_MUX_SYNC_BIT     12
`define SEL_TX_FUNC_LSB      13
`define SEL_TX_FUNC_MSB      14
`define SEL_OPTICAL_RX_BIT   15
`define PIN_SELECT_WIDTH     16

`define DIR_RX_PIN_BIT       8
`define DIR_TX_PIN_BIT       9
`define GPIO_REG_WIDTH       10

`define TX_FUNC_GPIO         2'h0
`define TX_FUNC_OPTICAL      2'h1
`define TX_FUNC_REAL         2'h2
`define TX_FUNC_REACTIVE     2'h3

`define STAT_BUTTON_FLAG_BIT 0
`define STAT_EMULATOR_BIT    1
`define STAT_PROD_TEST_BIT   2

`define RESET_PIN_SELECT     16'h0000
`define RESET_GPIO_DIRECTION 10'h000
`define RESET_GPIO_OUTPUT    10'h000
`define RESET_TEST_SELECT    4'h0

`define EEPROM_CLOCK_INDEX   0
`define EEPROM_DATA_INDEX    1
`define REAL_PULSE_INDEX     2
`define REACTIVE_PULSE_INDEX 3

`endif

// ===== rtl/meter_soc_pin_function_mux.v
/*
  Pin function mux of the metering chip: segment versus alternate function on
  every multi-use segment pin, optical or general I/O on I/O 1 and I/O 2, test multiplexer, chip reset pin and push-button wake.
  Assumes pins are synchronous to clk and the pad ring resolves out/oe pairs.
*/
`timescale 1ns/100ps
`include "pin_mux_consts.vh"

// How it works
// R1: with the emulator enable high the three emulator pins serve the emulator port, low they drive segments.
// R2: with the emulator enable low the emulator reset, clock and data pins carry segments 32, 33 and 38.
// R3: a high level on the chip reset pin holds the chip and this block's settings in reset.
// R4: a rising edge on the push button sets the sticky push-button flag.
// R5: that rising edge also raises a wake request while in sleep or LCD-only mode.
// R6: the test mux pin shows the internal signal picked by the four-bit test select field.
// R7: the clock-test and mux-sync pins each drive their special signal or their segment per an enable bit.
// R8: each shared pin is segment or general I/O, and the EEPROM option puts clock on I/O 4, data on I/O 5.
// R9: the pulse option puts the real-energy pulse on I/O 6 and the reactive pulse on I/O 7.
// R10: segments 3 to 6 are segments or the slave SPI clock, data out, select and data in.
// R11: the I/O 1 pin is the optical receive input or general I/O.
// R12: the I/O 2 pin is optical transmit, real pulse, reactive pulse or general I/O.
// R13: the four common outputs carry the display backplane selects.
// R14: the system keeps the production test input low in normal use.
// R15: software sets unused multi-use pins to outputs unless the board ties them off.
// R16: a pin given a non-segment function has its segment drive turned off.
module meter_soc_pin_function_mux #(
  parameter GPIO_PINS = 8
) (
  input  wire                 clk,
  input  wire                 reset_n,
  input  wire                 clk_en,
  input  wire [7:0]           addr,
  input  wire [31:0]          wdata,
  input  wire                 wr,
  input  wire                 rd,
  output reg  [31:0]          rdata,
  input  wire                 chip_reset_pin,
  output reg                  chip_reset,
  input  wire                 production_test_enable,
  input  wire                 emulator_port_enable,
  input  wire                 emulator_reset_pin_in,
  output reg                  emulator_reset_pin_out,
  output reg                  emulator_reset_pin_oe,
  output reg                  emulator_clock_pin_out,
  output reg                  emulator_clock_pin_oe,
  input  wire                 emulator_data_pin_in,
  output reg                  emulator_data_pin_out,
  output reg                  emulator_data_pin_oe,
  output reg                  emulator_reset,
  input  wire                 emulator_clock_source,
  input  wire                 emulator_data_source,
  input  wire                 emulator_data_source_oe,
  output reg                  emulator_data_receive,
  input  wire [2:0]           segment_for_emulator,
  output reg  [2:0]           emulator_segment_enable,
  input  wire [3:0]           spi_pin_in,
  output reg  [3:0]           spi_pin_out,
  output reg  [3:0]           spi_pin_oe,
  input  wire [3:0]           segment_for_spi,
  output reg  [3:0]           spi_segment_enable,
  output reg                  spi_clock,
  output reg                  spi_select_n,
  output reg                  spi_data_in,
  input  wire                 spi_data_out,
  input  wire [GPIO_PINS-1:0] shared_pin_in,
  output reg  [GPIO_PINS-1:0] shared_pin_out,
  output reg  [GPIO_PINS-1:0] shared_pin_oe,
  input  wire [GPIO_PINS-1:0] segment_for_shared,
  output reg  [GPIO_PINS-1:0] shared_segment_enable,
  input  wire                 eeprom_clock_out,
  input  wire                 eeprom_data_drive_low,
  output reg                  eeprom_data_in,
  input  wire                 real_energy_pulse,
  input  wire                 reactive_energy_pulse,
  input  wire                 optical_rx_pin_in,
  output reg                  optical_rx_pin_out,
  output reg                  optical_rx_pin_oe,
  output reg                  optical_receive_input,
  input  wire                 optical_tx_pin_in,
  output reg                  optical_tx_pin_out,
  output reg                  optical_tx_pin_oe,
  input  wire                 optical_transmit_output,
  input  wire                 clock_test_output,
  input  wire                 segment_for_clock_test,
  output reg                  clock_test_pin_out,
  input  wire                 multiplexer_sync_output,
  input  wire                 segment_for_mux_sync,
  output reg                  mux_sync_pin_out,
  input  wire [15:0]          test_signals,
  output reg                  test_mux_output_pin,
  input  wire [3:0]           lcd_common_drive,
  output reg  [3:0]           lcd_common_output,
  input  wire                 push_button_input,
  input  wire                 sleep_mode,
  input  wire                 lcd_only_mode,
  output reg                  wake_request,
  output reg                  push_button_flag
);

  reg [`PIN_SELECT_WIDTH-1:0] pin_select;
  reg [`GPIO_REG_WIDTH-1:0]   gpio_direction;
  reg [`GPIO_REG_WIDTH-1:0]   gpio_output;
  reg [3:0]                   test_select_field;
  reg                         button_last;
  reg [GPIO_PINS-1:0]         next_shared_out;
  reg [GPIO_PINS-1:0]         next_shared_oe;
  reg [GPIO_PINS-1:0]         next_shared_segment;
  reg                         next_tx_out;
  reg                         next_tx_oe;
  reg [31:0]                  next_rdata;
  integer                     i;

  wire       eeprom_enable     = pin_select[`SEL_EEPROM_BIT];
  wire       pulse_enable      = pin_select[`SEL_PULSE_BIT];
  wire       spi_enable        = pin_select[`SEL_SPI_BIT];
  wire       clock_test_output_enable = pin_select[`SEL_CLOCK_TEST_BIT];
  wire       mux_sync_output_enable   = pin_select[`SEL_MUX_SYNC_BIT];
  wire [1:0] tx_function       = pin_select[`SEL_TX_FUNC_MSB:`SEL_TX_FUNC_LSB];
  wire       optical_rx_select = pin_select[`SEL_OPTICAL_RX_BIT];
  wire       button_rise       = push_button_input & ~button_last;
  wire       write_status      = wr & (addr == `ADDR_STATUS);

  // picks one internal signal for the test pin
  function test_pick;
    input [15:0] signals;
    input [3:0]  select;
    begin
      test_pick = signals[select];
    end
  endfunction

  // shared segment / general I/O pins; index k is I/O number k+4
  always @*
  begin
    next_shared_out     = segment_for_shared;
    next_shared_oe      = {GPIO_PINS{1'b1}};
    next_shared_segment = {GPIO_PINS{1'b1}};
    for (i = 0; i < GPIO_PINS; i = i + 1)
    begin
      if (eeprom_enable && i == `EEPROM_CLOCK_INDEX)
      begin
        next_shared_out[i]     = eeprom_clock_out; // R8
        next_shared_oe[i]      = 1'b1;
        next_shared_segment[i] = 1'b0; // R16
      end
      else if (eeprom_enable && i == `EEPROM_DATA_INDEX)
      begin
        // open-drain data line, only ever pulled low
        next_shared_out[i]     = 1'b0; // R8
        next_shared_oe[i]      = eeprom_data_drive_low;
        next_shared_segment[i] = 1'b0; // R16
      end
      else if (pulse_enable && i == `REAL_PULSE_INDEX)
      begin
        next_shared_out[i]     = real_energy_pulse; // R9
        next_shared_oe[i]      = 1'b1;
        next_shared_segment[i] = 1'b0; // R16
      end
      else if (pulse_enable && i == `REACTIVE_PULSE_INDEX)
      begin
        next_shared_out[i]     = reactive_energy_pulse; // R9
        next_shared_oe[i]      = 1'b1;
        next_shared_segment[i] = 1'b0; // R16
      end
      else if (pin_select[i])
      begin
        next_shared_out[i]     = gpio_output[i]; // R8
        next_shared_oe[i]      = gpio_direction[i];
        next_shared_segment[i] = 1'b0; // R16
      end
    end
  end

  // optical transmit pin function choice
  always @*
  begin
    next_tx_out = gpio_output[`DIR_TX_PIN_BIT];
    next_tx_oe  = gpio_direction[`DIR_TX_PIN_BIT];
    case (tx_function)
      `TX_FUNC_OPTICAL:
      begin
        next_tx_out = optical_transmit_output; // R12
        next_tx_oe  = 1'b1;
      end
      `TX_FUNC_REAL:
      begin
        next_tx_out = real_energy_pulse; // R12
        next_tx_oe  = 1'b1;
      end
      `TX_FUNC_REACTIVE:
      begin
        next_tx_out = reactive_energy_pulse; // R12
        next_tx_oe  = 1'b1;
      end
      default:
      begin
        next_tx_out = gpio_output[`DIR_TX_PIN_BIT];
        next_tx_oe  = gpio_direction[`DIR_TX_PIN_BIT];
      end
    endcase
  end

  // read data; unmapped addresses read zero
  always @*
  begin
    next_rdata = 32'h0000_0000;
    if (addr == `ADDR_PIN_SELECT)
      next_rdata[`PIN_SELECT_WIDTH-1:0] = pin_select;
    else if (addr == `ADDR_GPIO_DIRECTION)
      next_rdata[`GPIO_REG_WIDTH-1:0] = gpio_direction;
    else if (addr == `ADDR_GPIO_OUTPUT)
      next_rdata[`GPIO_REG_WIDTH-1:0] = gpio_output;
    else if (addr == `ADDR_GPIO_INPUT)
    begin
      next_rdata[GPIO_PINS-1:0]         = shared_pin_in;
      next_rdata[`DIR_RX_PIN_BIT]       = optical_rx_pin_in;
      next_rdata[`DIR_TX_PIN_BIT]       = optical_tx_pin_in;
    end
    else if (addr == `ADDR_TEST_SELECT)
      next_rdata[3:0] = test_select_field;
    else if (addr == `ADDR_STATUS)
    begin
      next_rdata[`STAT_BUTTON_FLAG_BIT] = push_button_flag;
      next_rdata[`STAT_EMULATOR_BIT]    = emulator_port_enable;
      next_rdata[`STAT_PROD_TEST_BIT]   = production_test_enable;
    end
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_select              <= `RESET_PIN_SELECT;
      gpio_direction          <= `RESET_GPIO_DIRECTION;
      gpio_output             <= `RESET_GPIO_OUTPUT;
      test_select_field       <= `RESET_TEST_SELECT;
      button_last             <= 1'b0;
      push_button_flag        <= 1'b0;
      wake_request            <= 1'b0;
      chip_reset              <= 1'b1;
      rdata                   <= 32'h0000_0000;
      emulator_reset_pin_out  <= 1'b0;
      emulator_reset_pin_oe   <= 1'b0;
      emulator_clock_pin_out  <= 1'b0;
      emulator_clock_pin_oe   <= 1'b0;
      emulator_data_pin_out   <= 1'b0;
      emulator_data_pin_oe    <= 1'b0;
      emulator_reset          <= 1'b0;
      emulator_data_receive   <= 1'b0;
      emulator_segment_enable <= 3'h0;
      spi_pin_out             <= 4'h0;
      spi_pin_oe              <= 4'h0;
      spi_segment_enable      <= 4'h0;
      spi_clock               <= 1'b0;
      spi_select_n            <= 1'b1;
      spi_data_in             <= 1'b0;
      shared_pin_out          <= {GPIO_PINS{1'b0}};
      shared_pin_oe           <= {GPIO_PINS{1'b0}};
      shared_segment_enable   <= {GPIO_PINS{1'b0}};
      eeprom_data_in          <= 1'b1;
      optical_rx_pin_out      <= 1'b0;
      optical_rx_pin_oe       <= 1'b0;
      optical_receive_input   <= 1'b0;
      optical_tx_pin_out      <= 1'b0;
      optical_tx_pin_oe       <= 1'b0;
      clock_test_pin_out      <= 1'b0;
      mux_sync_pin_out        <= 1'b0;
      test_mux_output_pin     <= 1'b0;
      lcd_common_output       <= 4'h0;
    end
    else if (clk_en)
    begin
      chip_reset <= chip_reset_pin; // R3
      if (chip_reset_pin)
      begin
        pin_select        <= `RESET_PIN_SELECT; // R3
        gpio_direction    <= `RESET_GPIO_DIRECTION;
        gpio_output       <= `RESET_GPIO_OUTPUT;
        test_select_field <= `RESET_TEST_SELECT;
        push_button_flag  <= 1'b0;
      end
      else
      begin
        if (wr && addr == `ADDR_PIN_SELECT)
          pin_select <= wdata[`PIN_SELECT_WIDTH-1:0];
        if (wr && addr == `ADDR_GPIO_DIRECTION)
          gpio_direction <= wdata[`GPIO_REG_WIDTH-1:0];
        if (wr && addr == `ADDR_GPIO_OUTPUT)
          gpio_output <= wdata[`GPIO_REG_WIDTH-1:0];
        if (wr && addr == `ADDR_TEST_SELECT)
          test_select_field <= wdata[3:0];
        // set beats a same-cycle write-one clear
        if (button_rise)
          push_button_flag <= 1'b1; // R4
        else if (write_status && wdata[`STAT_BUTTON_FLAG_BIT])
          push_button_flag <= 1'b0;
      end
      button_last  <= push_button_input;
      wake_request <= button_rise & (sleep_mode | lcd_only_mode); // R5
      rdata        <= rd ? next_rdata : 32'h0000_0000;

      if (emulator_port_enable)
      begin
        emulator_reset_pin_out  <= 1'b0; // R1
        emulator_reset_pin_oe   <= 1'b0;
        emulator_reset          <= emulator_reset_pin_in;
        emulator_clock_pin_out  <= emulator_clock_source;
        emulator_clock_pin_oe   <= 1'b1;
        emulator_data_pin_out   <= emulator_data_source;
        emulator_data_pin_oe    <= emulator_data_source_oe;
        emulator_data_receive   <= emulator_data_pin_in;
        emulator_segment_enable <= 3'h0; // R16
      end
      else
      begin
        emulator_reset_pin_out  <= segment_for_emulator[0]; // R2
        emulator_reset_pin_oe   <= 1'b1;
        emulator_reset          <= 1'b0;
        emulator_clock_pin_out  <= segment_for_emulator[1]; // R2
        emulator_clock_pin_oe   <= 1'b1;
        emulator_data_pin_out   <= segment_for_emulator[2]; // R2
        emulator_data_pin_oe    <= 1'b1;
        emulator_data_receive   <= 1'b0;
        emulator_segment_enable <= 3'h7; // R1
      end

      if (spi_enable)
      begin
        spi_pin_out        <= {3'h0, 1'b0} | {2'h0, spi_data_out, 1'b0}; // R10
        spi_pin_oe         <= 4'h2;
        spi_segment_enable <= 4'h0; // R16
        spi_clock          <= spi_pin_in[0];
        spi_select_n       <= spi_pin_in[2];
        spi_data_in        <= spi_pin_in[3];
      end
      else
      begin
        spi_pin_out        <= segment_for_spi; // R10
        spi_pin_oe         <= 4'hF;
        spi_segment_enable <= 4'hF;
        spi_clock          <= 1'b0;
        spi_select_n       <= 1'b1;
        spi_data_in        <= 1'b0;
      end

      shared_pin_out        <= next_shared_out;
      shared_pin_oe         <= next_shared_oe;
      shared_segment_enable <= next_shared_segment;
      eeprom_data_in        <= eeprom_enable ? shared_pin_in[`EEPROM_DATA_INDEX] : 1'b1;

      optical_rx_pin_out    <= gpio_output[`DIR_RX_PIN_BIT];
      optical_rx_pin_oe     <= optical_rx_select ? 1'b0 : gpio_direction[`DIR_RX_PIN_BIT]; // R11
      optical_receive_input <= optical_rx_select & optical_rx_pin_in; // R11
      optical_tx_pin_out    <= next_tx_out;
      optical_tx_pin_oe     <= next_tx_oe;

      clock_test_pin_out  <= clock_test_output_enable ? clock_test_output
                                                       : segment_for_clock_test; // R7
      mux_sync_pin_out    <= mux_sync_output_enable ? multiplexer_sync_output
                                                     : segment_for_mux_sync; // R7
      test_mux_output_pin <= test_pick(test_signals, test_select_field); // R6
      lcd_common_output   <= lcd_common_drive; // R13
    end
  end

endmodule // meter_soc_pin_function_mux

// ===== dv/pin_mux_monitor.sv
/*
  Port-level checks for the pin function mux.
  Assumes a bind to meter_soc_pin_function_mux and a single clock domain.
*/
`timescale 1ns/100ps
module pin_mux_monitor (
  input wire        clk,
  input wire        reset_n,
  input wire        clk_en,
  input wire        rd,
  input wire        wr,
  input wire [31:0] rdata,
  input wire        chip_reset_pin,
  input wire        chip_reset,
  input wire        emulator_port_enable,
  input wire        emulator_reset_pin_in,
  input wire        emulator_data_pin_in,
  input wire        emulator_reset,
  input wire        emulator_data_receive,
  input wire [2:0]  emulator_segment_enable,
  input wire [3:0]  lcd_common_drive,
  input wire [3:0]  lcd_common_output,
  input wire        push_button_input,
  input wire        sleep_mode,
  input wire        lcd_only_mode,
  input wire        wake_request,
  input wire        push_button_flag
);
  reg  button_seen;
  wire button_rise;
  assign button_rise = push_button_input & ~button_seen;
  // previous sampled button level, frozen like the design when clk_en is low
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
      button_seen <= 1'b0;
    else if (clk_en)
      button_seen <= push_button_input;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_emu_segment_off: assert property (
    clk_en |=> emulator_segment_enable == {3{~$past(emulator_port_enable)}})
    else $error("emulator pin segment enable wrong");
  a_emu_reset_route: assert property (
    clk_en |=> emulator_reset == ($past(emulator_port_enable) & $past(emulator_reset_pin_in)))
    else $error("emulator reset routing wrong");
  a_emu_data_route: assert property (
    clk_en |=> emulator_data_receive == ($past(emulator_port_enable) & $past(emulator_data_pin_in)))
    else $error("emulator data routing wrong");
  a_chip_reset_copy: assert property (
    clk_en |=> chip_reset == $past(chip_reset_pin))
    else $error("chip reset does not follow pin");
  a_button_flag_set: assert property (
    clk_en && button_rise && !chip_reset_pin |=> push_button_flag)
    else $error("button rise did not set flag");
  a_button_flag_hold: assert property (
    clk_en && push_button_flag && !wr && !chip_reset_pin |=> push_button_flag)
    else $error("button flag dropped by itself");
  a_wake_one_pulse: assert property (
    clk_en |=> wake_request == ($past(button_rise) & ($past(sleep_mode) | $past(lcd_only_mode))))
    else $error("wake request wrong");
  a_common_copy: assert property (
    clk_en |=> lcd_common_output == $past(lcd_common_drive))
    else $error("common outputs wrong");
  a_rdata_quiet: assert property (
    clk_en && !rd |=> rdata == 32'h0000_0000)
    else $error("read data outside answer cycle");
endmodule // pin_mux_monitor

bind meter_soc_pin_function_mux pin_mux_monitor u_mon (.clk(clk), .reset_n(reset_n),
  .clk_en(clk_en), .rd(rd), .wr(wr), .rdata(rdata), .chip_reset_pin(chip_reset_pin),
  .chip_reset(chip_reset), .emulator_port_enable(emulator_port_enable),
  .emulator_reset_pin_in(emulator_reset_pin_in), .emulator_data_pin_in(emulator_data_pin_in),
  .emulator_reset(emulator_reset), .emulator_data_receive(emulator_data_receive),
  .emulator_segment_enable(emulator_segment_enable), .lcd_common_drive(lcd_common_drive),
  .lcd_common_output(lcd_common_output), .push_button_input(push_button_input),
  .sleep_mode(sleep_mode), .lcd_only_mode(lcd_only_mode), .wake_request(wake_request),
  .push_button_flag(push_button_flag));

// ===== dv/tb.sv
/*
  Self-checking bench for the pin function mux.
  Assumes the design and monitor are compiled first; the bench drives every pin itself.
*/
`timescale 1ns/100ps
module tb;
  reg        clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, wr = 1'b0, rd = 1'b0;
  reg        chip_reset_pin = 1'b0, production_test_enable = 1'b0, emulator_port_enable = 1'b0;
  reg        emulator_reset_pin_in = 1'b1, emulator_data_pin_in = 1'b1;
  reg        emulator_clock_source = 1'b0, emulator_data_source = 1'b1;
  reg        emulator_data_source_oe = 1'b0, spi_data_out = 1'b1, eeprom_clock_out = 1'b1;
  reg        eeprom_data_drive_low = 1'b1, real_energy_pulse = 1'b0, reactive_energy_pulse = 1'b1;
  reg        optical_rx_pin_in = 1'b1, optical_tx_pin_in = 1'b0, optical_transmit_output = 1'b1;
  reg        clock_test_output = 1'b1, segment_for_clock_test = 1'b0;
  reg        multiplexer_sync_output = 1'b0, segment_for_mux_sync = 1'b1;
  reg        push_button_input = 1'b0, sleep_mode = 1'b0, lcd_only_mode = 1'b0;
  reg [2:0]  segment_for_emulator = 3'h5;
  reg [3:0]  spi_pin_in = 4'h9, segment_for_spi = 4'h6, lcd_common_drive = 4'h9;
  reg [7:0]  addr = 8'h00, shared_pin_in = 8'hA4, segment_for_shared = 8'h5A;
  reg [15:0] test_signals = 16'hA5C3;
  reg [31:0] wdata = 32'h0000_0000;
  wire [31:0] rdata;
  wire [7:0]  shared_pin_out, shared_pin_oe, shared_segment_enable;
  wire [3:0]  spi_pin_out, spi_pin_oe, spi_segment_enable, lcd_common_output;
  wire [2:0]  emulator_segment_enable;
  wire        chip_reset, emulator_reset_pin_out, emulator_reset_pin_oe, emulator_clock_pin_out;
  wire        emulator_clock_pin_oe, emulator_data_pin_out, emulator_data_pin_oe, emulator_reset;
  wire        emulator_data_receive, spi_clock, spi_select_n, spi_data_in, eeprom_data_in;
  wire        optical_rx_pin_out, optical_rx_pin_oe, optical_receive_input, optical_tx_pin_out;
  wire        optical_tx_pin_oe, clock_test_pin_out, mux_sync_pin_out, test_mux_output_pin;
  wire        wake_request, push_button_flag;
  integer     err_total = 0;
  integer     num_checks = 0;
  integer     i;
  reg  [31:0] rd_val;

  meter_soc_pin_function_mux #(.GPIO_PINS(8)) DUT (.*);

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  task check(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        err_total = err_total + 1;
        $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task wait_pins;
    begin
      repeat (2) @(posedge clk);
      #1;
    end
  endtask

  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wait_pins;
    end
  endtask

  task rd_reg(input [7:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      rd_val = rdata;
    end
  endtask

  task t_emulator;
    begin
      check(emulator_segment_enable, 3'h7);
      check({emulator_data_pin_out, emulator_clock_pin_out}, 2'h2);
      @(posedge clk);
      emulator_port_enable <= 1'b1;
      wait_pins;
      check(emulator_segment_enable, 3'h0);
      check(emulator_clock_pin_out, emulator_clock_source);
      check({emulator_reset, emulator_data_receive}, 2'h3);
      rd_reg(8'h14);
      check(rd_val[2:1], 2'h1);
      @(posedge clk);
      emulator_port_enable <= 1'b0;
      wait_pins;
    end
  endtask

  task t_chip_reset;
    begin
      wr_reg(8'h00, 32'h0000_0400);
      @(posedge clk);
      chip_reset_pin <= 1'b1;
      wait_pins;
      check(chip_reset, 1'b1);
      wr_reg(8'h00, 32'h0000_0800);
      rd_reg(8'h00);
      check(rd_val, 32'h0000_0000);
      @(posedge clk);
      chip_reset_pin <= 1'b0;
      wait_pins;
      check(chip_reset, 1'b0);
    end
  endtask

  task pulse_button(input [31:0] exp_wake);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      push_button_input <= 1'b1;
      repeat (5)
      begin
        @(posedge clk);
        #1;
        if (wake_request === 1'b1)
          n = n + 1;
      end
      check(n, exp_wake);
      check(push_button_flag, 1'b1);
      @(posedge clk);
      push_button_input <= 1'b0;
      wr_reg(8'h14, 32'h0000_0001);
      check(push_button_flag, 1'b0);
    end
  endtask

  task t_button;
    begin
      sleep_mode <= 1'b1;
      pulse_button(1);
      sleep_mode <= 1'b0;
      lcd_only_mode <= 1'b1;
      pulse_button(1);
      lcd_only_mode <= 1'b0;
      pulse_button(0);
    end
  endtask

  task t_outputs;
    begin
      for (i = 0; i < 16; i = i + 1)
      begin
        wr_reg(8'h10, i);
        check(test_mux_output_pin, test_signals[i]);
      end
      check({clock_test_pin_out, mux_sync_pin_out}, 2'h1);
      wr_reg(8'h00, 32'h0000_1800);
      check({clock_test_pin_out, mux_sync_pin_out}, 2'h2);
      check(lcd_common_output, lcd_common_drive);
    end
  endtask

  task t_shared;
    begin
      wr_reg(8'h04, 32'h0000_0030);
      wr_reg(8'h08, 32'h0000_0010);
      wr_reg(8'h00, 32'h0000_03F0);
      check(shared_segment_enable, 8'h00);
      check({shared_pin_out[3:2], shared_pin_out[0]}, 3'h5);
      check({shared_pin_out[5:4], shared_pin_out[1]}, 3'h2);
      check({shared_pin_oe[7:4], shared_pin_oe[1]}, 5'h07);
      check(eeprom_data_in, shared_pin_in[1]);
      rd_reg(8'h0C);
      check(rd_val, {22'h0, optical_tx_pin_in, optical_rx_pin_in, shared_pin_in});
      wr_reg(8'h00, 32'h0000_0000);
      check({shared_segment_enable, shared_pin_out}, {8'hFF, segment_for_shared});
    end
  endtask

  task t_spi;
    begin
      check({spi_segment_enable, spi_select_n}, 5'h1F);
      wr_reg(8'h00, 32'h0000_0400);
      check(spi_segment_enable, 4'h0);
      check({spi_clock, spi_select_n, spi_data_in}, 3'h5);
      check({spi_pin_out[1], spi_pin_oe[1]}, {spi_data_out, 1'b1});
    end
  endtask

  task t_optical;
    begin
      wr_reg(8'h00, 32'h0000_8000);
      check(optical_receive_input, optical_rx_pin_in);
      for (i = 1; i < 4; i = i + 1)
      begin
        wr_reg(8'h00, i << 13);
        check(optical_tx_pin_out, 1'b1);
        @(posedge clk);
        optical_transmit_output <= ~optical_transmit_output;
        real_energy_pulse <= ~real_energy_pulse;
        reactive_energy_pulse <= ~reactive_energy_pulse;
        wait_pins;
        check({optical_tx_pin_out, optical_tx_pin_oe}, 2'h1);
      end
      wr_reg(8'h04, 32'h0000_0200);
      wr_reg(8'h08, 32'h0000_0200);
      wr_reg(8'h00, 32'h0000_0000);
      check({optical_tx_pin_out, optical_tx_pin_oe, optical_rx_pin_oe}, 3'h6);
      check(optical_receive_input, 1'b0);
    end
  endtask

  task stop_test;
    begin
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    check({chip_reset, spi_select_n, eeprom_data_in}, 3'h7);
    @(posedge clk);
    reset_n <= 1'b1;
    wait_pins;
    rd_reg(8'h20);
    check(rd_val, 32'h0000_0000);
    t_emulator;
    t_chip_reset;
    t_button;
    t_outputs;
    t_shared;
    t_spi;
    t_optical;
    stop_test;
  end

  initial
  begin
    #20000;
    err_total = err_total + 1;
    stop_test;
  end
endmodule // tb
